// file: logic/dbss_regs.svh
// register offsets, field positions, reset values and widths of the holding-buffer save stack
`ifndef DBSS_REGS_SVH
`define DBSS_REGS_SVH

////////////////////////////////////////////////////////////////////////////////
// peripheral address space
`define DBSS_ADDR_W 7
`define DBSS_DATA_W 16
`define DBSS_OFS_LEVEL 7'h04
`define DBSS_OFS_PORT 7'h41

////////////////////////////////////////////////////////////////////////////////
// level register layout
`define DBSS_LEVEL_W 4
`define DBSS_LEVEL_LOW_POS 0
`define DBSS_LEVEL_HIGH_POS 1
`define DBSS_LEVEL_RESET 4'h0

////////////////////////////////////////////////////////////////////////////////
// stack geometry and the value handed back for undefined reads
`define DBSS_DEPTH 4
`define DBSS_UNDEF_VALUE 16'h0000

`endif

// file: logic/dbss_pkg.sv
// types shared by the holding-buffer save stack
`include "dbss_regs.svh"

package dbss_pkg;

  // one peripheral transfer from the core: store (holding buffer out) or load
  typedef struct packed {
    logic valid;
    logic store;
    logic [`DBSS_ADDR_W-1:0] addr;
    logic [`DBSS_DATA_W-1:0] data;
  } dbss_req_t;

  // answer to a load, bound for the holding buffer
  typedef struct packed {
    logic valid;
    logic [`DBSS_DATA_W-1:0] data;
  } dbss_rsp_t;

  // decoded target of a transfer
  typedef enum logic [1:0] {
    DBSS_TGT_NONE,
    DBSS_TGT_LEVEL,
    DBSS_TGT_PORT
  } dbss_tgt_t;

endpackage : dbss_pkg

// file: logic/dbss_stack.sv
// holding-buffer save stack: four 16-bit slots pushed by store and popped by load
`include "dbss_regs.svh"

module dbss_stack #(
  parameter int DEPTH = `DBSS_DEPTH,
  parameter logic [`DBSS_DATA_W-1:0] UNDEF_VALUE = `DBSS_UNDEF_VALUE
) (
  // clock, reset, enable
  input wire logic mclk,
  input wire logic srst,
  input wire logic clk_en,
  // peripheral transfer from the core
  input wire dbss_pkg::dbss_req_t req,
  // answer into the holding buffer
  output dbss_pkg::dbss_rsp_t rsp,
  // current level register contents
  output logic [`DBSS_LEVEL_W-1:0] level
);
  import dbss_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);

  ////////////////////////////////////////////////////////////////////////////////
  // address decode

  // bank select never reaches this decode, so any bank works the same
  function automatic dbss_tgt_t decode(input logic [`DBSS_ADDR_W-1:0] addr);
    dbss_tgt_t tgt;
    tgt = DBSS_TGT_NONE;
    if (addr == `DBSS_OFS_PORT) begin
      tgt = DBSS_TGT_PORT;
    end else if (addr == `DBSS_OFS_LEVEL) begin
      tgt = DBSS_TGT_LEVEL;
    end
    return tgt;
  endfunction : decode

  dbss_tgt_t tgt;
  logic push;
  logic pop;
  logic level_rd;

  // one decode shared by the stack, the level register and the answer path
  always_comb begin
    tgt = decode(req.addr);
    push = clk_en && req.valid && req.store && (tgt == DBSS_TGT_PORT);
    pop = clk_en && req.valid && !req.store && (tgt == DBSS_TGT_PORT);
    level_rd = clk_en && req.valid && !req.store && (tgt == DBSS_TGT_LEVEL);
  end

  ////////////////////////////////////////////////////////////////////////////////
  // slot storage

  // no reset on the slots: their contents after power-up are undefined anyway
  logic [`DBSS_DATA_W-1:0] slot [DEPTH];
  logic [`DBSS_DATA_W-1:0] next_slot [DEPTH];
  logic [PTR_W-1:0] ptr;
  logic [`DBSS_DATA_W-1:0] slot_at_ptr;
  logic slot_we;

  always_comb begin
    slot_at_ptr = slot[ptr];
    slot_we = push;
  end

  // only the slot under the pointer takes a store; every other slot carries its word over
  // wrap of the pointer means a fifth push lands on the oldest entry
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      next_slot[i] = slot[i];
    end
    if (slot_we) begin
      next_slot[ptr] = req.data;
    end
  end

  // slots only register; clock enable low drops slot_we, so they hold like a stopped clock
  always_ff @(posedge mclk) begin
    slot <= next_slot;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // level register

  logic [`DBSS_LEVEL_W-1:0] next_level;

  // stores to the level address fall through untouched: the register is read-only
  always_comb begin
    next_level = level;
    if (push) begin
      next_level = {{(`DBSS_LEVEL_W-PTR_W){1'b0}}, ptr + PTR_W'(1)};
    end else if (pop) begin
      next_level = {{(`DBSS_LEVEL_W-PTR_W){1'b0}}, ptr - PTR_W'(1)};
    end
  end

  // clock enable low holds the pointer, like a stopped clock
  always_ff @(posedge mclk) begin
    if (srst) begin
      level <= `DBSS_LEVEL_RESET;
    end else if (clk_en) begin
      level <= next_level;
    end
  end

  assign ptr = level[PTR_W-1:0];

  ////////////////////////////////////////////////////////////////////////////////
  // answer path

  dbss_rsp_t next_rsp;

  // a load reads the slot under the pointer before stepping down, so a load straight after a store
  // returns the slot above the word just pushed, not that word
  // only loads answer; unused addresses give the fixed undefined pattern
  always_comb begin
    next_rsp.valid = clk_en && req.valid && !req.store;
    next_rsp.data = UNDEF_VALUE;
    if (pop) begin
      next_rsp.data = slot_at_ptr;
    end else if (level_rd) begin
      next_rsp.data = {{(`DBSS_DATA_W-`DBSS_LEVEL_W){1'b0}}, level};
    end
  end

  // answer stands one cycle when enabled, frozen otherwise
  always_ff @(posedge mclk) begin
    if (srst) begin
      rsp <= '0;
    end else if (clk_en) begin
      rsp <= next_rsp;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  // every check but the reset one is gated off while reset stands
  // slot checks assume the slot was written once: an unwritten slot reads unknown and trips them
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  sequence s_push;
    push;
  endsequence

  sequence s_four_push;
    s_push ##1 s_push ##1 s_push ##1 s_push;
  endsequence

  sequence s_pop;
    pop;
  endsequence

  sequence s_pop_pair;
    s_pop ##1 s_pop;
  endsequence

  a_push_advances: assert property (push |=> ptr == PTR_W'($past(ptr) + PTR_W'(1)))
    else $error("pointer did not advance after a stack store");

  a_push_stores: assert property (push |=> slot[$past(ptr)] == $past(req.data))
    else $error("stack store did not land in the selected slot");

  a_pop_retreats: assert property (pop |=> ptr == PTR_W'($past(ptr) - PTR_W'(1)))
    else $error("pointer did not retreat after a stack load");

  a_pop_data: assert property (pop |=> rsp.valid && rsp.data == $past(slot_at_ptr))
    else $error("stack load returned the wrong slot");

  a_ptr_steady: assert property (clk_en && !push && !pop |=> $stable(level))
    else $error("pointer moved without a stack access");

  a_level_readback: assert property (level_rd |=> rsp.valid && rsp.data == 16'($past(ptr)))
    else $error("level readback wrong");

  a_level_top_zero: assert property (level[`DBSS_LEVEL_W-1:PTR_W] == '0)
    else $error("upper level bits not zero");

  a_ro_write_ignored: assert property (
    clk_en && req.valid && req.store && tgt == DBSS_TGT_LEVEL |=> $stable(level))
    else $error("store to level register changed state");

  a_unused_load: assert property (
    clk_en && req.valid && !req.store && tgt == DBSS_TGT_NONE |=> rsp.data == UNDEF_VALUE)
    else $error("unused address load did not return undefined value");

  a_store_no_answer: assert property (clk_en && req.valid && req.store |=> !rsp.valid)
    else $error("store produced an answer");

  a_wrap_four: assert property (s_four_push |=> ptr == $past(ptr, 4))
    else $error("pointer did not wrap after four stores");

  a_reset_clear: assert property (disable iff (1'b0) srst |=> level == `DBSS_LEVEL_RESET && !rsp.valid)
    else $error("reset did not clear the level register");

  a_enable_freeze: assert property (!clk_en |=> $stable(level) && $stable(rsp))
    else $error("state moved with clock enable low");

  a_freeze_slots: assert property (!clk_en |=> $stable(slot_at_ptr))
    else $error("slot moved with clock enable low");

  a_pop_pair: assert property (s_pop_pair |=> ptr == PTR_W'($past(ptr, 2) - PTR_W'(2)))
    else $error("pointer did not fall by two after two stack loads");

  a_pop_keeps_slot: assert property (pop |=> slot[$past(ptr)] == $past(slot_at_ptr))
    else $error("stack load disturbed the slot it read");

  a_load_answers: assert property (clk_en && req.valid && !req.store |=> rsp.valid)
    else $error("load gave no answer");

  a_idle_quiet: assert property (clk_en && !req.valid |=> !rsp.valid)
    else $error("answer without a load");

  a_unused_store: assert property (
    clk_en && req.valid && req.store && tgt == DBSS_TGT_NONE |=> $stable(level) && $stable(slot_at_ptr))
    else $error("store to unused address changed state");

  a_ro_slots_kept: assert property (
    clk_en && req.valid && req.store && tgt == DBSS_TGT_LEVEL |=> $stable(slot_at_ptr))
    else $error("store to level register changed a slot");

endmodule : dbss_stack

// file: verification/dbss_core_model.sv
// processor core model issuing peripheral transfers to the save stack
module dbss_core_model (
  // clock
  input wire logic mclk,
  // transfer towards the stack
  output dbss_pkg::dbss_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // idle bus at time zero
  initial begin
    req <= '0;
  end

  // one-cycle pulse per transfer, driven on the falling edge
  // released fields flip so a stale value can never pass for a hold
  task automatic issue(input logic st, input logic [6:0] ad, input logic [15:0] d);
    @(negedge mclk);
    req <= '{1'b1, st, ad, d};
    @(negedge mclk);
    req <= '{1'b0, ~st, ~ad, ~d};
  endtask : issue

  // back-to-back transfer: one request per falling edge, valid kept up between them
  task automatic stream(input logic st, input logic [6:0] ad, input logic [15:0] d);
    @(negedge mclk);
    req <= '{1'b1, st, ad, d};
  endtask : stream

  // end of a run of back-to-back transfers
  task automatic rest();
    @(negedge mclk);
    req <= '{1'b0, ~req.store, ~req.addr, ~req.data};
  endtask : rest
endmodule : dbss_core_model

// file: verification/testbench.sv
// self-checking bench of the holding-buffer save stack
`include "dbss_regs.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import dbss_pkg::*;

  logic mclk;
  logic srst;
  logic clk_en;
  dbss_req_t req;
  dbss_rsp_t rsp;
  logic [`DBSS_LEVEL_W-1:0] level;
  logic [15:0] slot [4];
  logic [1:0] ptr;
  logic [31:0] r;
  logic [6:0] ad;
  logic [15:0] run_exp;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed;

  dbss_stack u_dut (.mclk(mclk), .srst(srst), .clk_en(clk_en), .req(req), .rsp(rsp), .level(level));
  dbss_core_model u_core (.mclk(mclk), .req(req));

  ////////////////////////////////////////////////////////////////////////////////
  // 200 MHz clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // compare with case equality so unknowns fail
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("errors %0d checks %0d", errors, total_checks);
    if (errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : final_report

  // what a load should return, from the reference stack and pointer kept here
  function automatic logic [15:0] expect_load(input logic [6:0] a);
    logic [15:0] e;
    e = `DBSS_UNDEF_VALUE;
    if (a == `DBSS_OFS_LEVEL) e = {14'h0, ptr};
    if (a == `DBSS_OFS_PORT) e = slot[ptr];
    return e;
  endfunction : expect_load

  // move the reference stack the way a transfer moves the real one
  task automatic advance(input logic st, input logic [6:0] a, input logic [15:0] d);
    if (a == `DBSS_OFS_PORT && st) slot[ptr] = d;
    if (a == `DBSS_OFS_PORT) ptr = st ? ptr + 2'h1 : ptr - 2'h1;
  endtask : advance

  // one transfer; expectation from a reference stack kept here
  task automatic xfer(input logic st, input logic [6:0] a, input logic [15:0] d);
    logic [15:0] exp;
    exp = expect_load(a);
    advance(st, a, d);
    u_core.issue(st, a, d);
    check("level", {12'h0, level}, {14'h0, ptr});
    check("answer valid", {15'h0, rsp.valid}, {15'h0, ~st});
    if (!st) check("load data", rsp.data, exp);
  endtask : xfer

  // cycle ceiling well above the few hundred transfers below
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      final_report();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 11039;
    srst = 1'b1;
    clk_en = 1'b1;
    ptr = 2'h0;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    check("level after reset", {12'h0, level}, 16'h0000);
    // six pushes: the last two overwrite the oldest entries; an interrupt-style save
    repeat (6) xfer(1'b1, `DBSS_OFS_PORT, 16'($random(seed)));
    repeat (5) xfer(1'b0, `DBSS_OFS_PORT, 16'h0000);
    xfer(1'b1, `DBSS_OFS_LEVEL, 16'hFFFF);
    xfer(1'b1, 7'h7F, 16'hFFFF);
    // stopped clock: a push must leave pointer and slots alone
    clk_en = 1'b0;
    u_core.issue(1'b1, `DBSS_OFS_PORT, 16'hA5A5);
    clk_en = 1'b1;
    check("frozen level", {12'h0, level}, {14'h0, ptr});
    // second reset in mid-run clears the pointer and the answer register, not the slots
    srst = 1'b1;
    @(negedge mclk);
    srst = 1'b0;
    ptr = 2'h0;
    check("level after second reset", {12'h0, level}, 16'h0000);
    // random mix; bit 5 forced on the unused address so it never hits a mapped one
    repeat (200) begin
      r = $random(seed);
      ad = r[1] ? `DBSS_OFS_PORT : (r[2] ? `DBSS_OFS_LEVEL : (r[10:4] | 7'h20));
      xfer(r[0], ad, r[31:16]);
    end
    // interrupt entry: four stores with no gap; the pointer comes all the way round
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      advance(1'b1, `DBSS_OFS_PORT, r[15:0]);
      u_core.stream(1'b1, `DBSS_OFS_PORT, r[15:0]);
    end
    u_core.rest();
    check("level after store run", {12'h0, level}, {14'h0, ptr});
    check("store run answer", {15'h0, rsp.valid}, 16'h0000);
    // four loads with no gap: each answer stands one cycle and is taken while the next load is driven
    for (int i = 0; i < 4; i++) begin
      u_core.stream(1'b0, `DBSS_OFS_PORT, 16'h0000);
      if (i > 0) begin
        check("run load valid", {15'h0, rsp.valid}, 16'h0001);
        check("run load data", rsp.data, run_exp);
      end
      run_exp = expect_load(`DBSS_OFS_PORT);
      advance(1'b0, `DBSS_OFS_PORT, 16'h0000);
    end
    u_core.rest();
    check("run load data", rsp.data, run_exp);
    check("level after load run", {12'h0, level}, {14'h0, ptr});
    final_report();
  end
endmodule : testbench
